// [gate_ctl_defines.vh]
/*
  Constants for the resonant half-bridge gate controller: clock rate,
  dead time, charge-rate units and clamps, ramp threshold, feedback code
  window and timing counts.
  Assumes a single 100 MHz system clock.
*/
`ifndef GATE_CTL_DEFINES_VH
`define GATE_CTL_DEFINES_VH

// Clock
`define CLK_MHZ          100

// Dead interval between gates
`define DEAD_NS          380
`define DEAD_CYC         ((`DEAD_NS * `CLK_MHZ + 999) / 1000)

// Charge-rate parts, in base steps of 16 units
`define BASE_RATE        7'h10
`define FB_PART_MAX      7'h20
`define CS_PART_MAX      7'h30
`define SS_PART_MAX      7'h36
`define CAP_NORMAL       7'h30
`define CAP_FAULT        7'h40
`define CAP_SOFT         7'h47
`define CAP_ABS          7'h50

// Ramp upper threshold in accumulator units
`define RAMP_TOP         14'h1900

// Feedback code window, 8-bit code of 0 V to 5 V
`define FB_LO_CODE       8'h2E
`define FB_HI_CODE       8'hC7
`define FB_SCALE         9'hD6

// Soft start: 32 steps over 32 ms
`define SS_TOTAL_MS      32
`define SS_STEPS         6'h20
`define SS_STEP_CYC      ((`SS_TOTAL_MS * 1000 * `CLK_MHZ) / 32)

// Current-sense part full swing time
`define CS_RAMP_US       1500
`define CS_STEP_CYC      ((`CS_RAMP_US * `CLK_MHZ) / 48)

// Burst blanking default
`define BURST_BLANK_US   10
`define BURST_BLANK_CYC  (`BURST_BLANK_US * `CLK_MHZ)

`endif

// [half_bridge_gate_ctl.v]
/*
  Gate timing core of a half-bridge resonant controller: phase
  accumulator oscillator, toggle stage with fixed dead time, four-part
  charge rate with clamps, 32-step soft start, current-sense frequency
  shift, burst stop/resume and supply on/off gating.
  Assumes all comparator flags and the feedback code are synchronous to
  clk_sys, and that external drivers follow the gate levels directly.
*/
// Notes on behaviour
// - Toggle stage alternates conduction between high and low gate every period.
// - Gates have equal duty, opposite phase, never both on.
// - Fixed dead interval with both gates off between every handover.
// - Gate on interval equals ramp charge phase, ends at upper threshold.
// - Dead interval is the fixed-rate discharge phase after each charge.
// - Charge rate is base plus feedback, current-sense and soft-start parts.
// - Current-sense part clamps at three times base.
// - Soft-start part clamps at about 3.4 times base.
// - Total charge rate never exceeds five times base.
// - Total capped at 3x normal, 4x under fault, 4.44x in soft start.
// - Higher feedback lowers frequency, lower feedback raises it.
// - Feedback part saturates outside the 0.9 V to 3.9 V window.
// - In run mode, feedback below burst-off for the blanking time stops both gates.
// - After burst stop, switching resumes once feedback exceeds burst-on.
// - Operation begins only after supply reaches its turn-on level.
// - Supply below turn-off level after turn-on stops and resets everything.
// - Soft start runs 32 equal steps over 32 ms, stepping its part.
// - Soft start begins high and steps frequency down toward minimum.
// - Overload protection stays disabled throughout soft start.
// - Current sense above first threshold raises current-sense part.
// - Current-sense part ramps full scale in 1.5 ms, down at same rate.
`timescale 1ns/1ps
`include "gate_ctl_defines.vh"

module half_bridge_gate_ctl #(
  parameter SS_STEP_CYCLES = `SS_STEP_CYC,
  parameter BURST_BLANK    = `BURST_BLANK_CYC
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       srst,
  // Supply comparators
  input  wire       supply_on_level,
  input  wire       supply_off_level,
  // Feedback code and burst comparators
  input  wire [7:0] feedback_input,
  input  wire       burst_off_threshold,
  input  wire       burst_on_threshold,
  // Current-sense comparators
  input  wire       cs_above_high,
  input  wire       cs_below_low,
  // Gate drives
  output reg        high_side_gate,
  output reg        low_side_gate,
  // Status
  output reg        soft_start_active,
  output reg        overload_enable,
  output reg        switching_active
);

  localparam MODE_OFF   = 2'h0;
  localparam MODE_SOFT  = 2'h1;
  localparam MODE_RUN   = 2'h2;
  localparam MODE_BURST = 2'h3;

  localparam PH_CHARGE  = 1'b0;
  localparam PH_DEAD    = 1'b1;

  // Gate rises one cycle after the dead phase ends, so the phase ends one early
  localparam integer DEAD_LAST_I  = `DEAD_CYC - 2;
  localparam integer SS_LAST_I    = SS_STEP_CYCLES - 1;
  localparam integer CS_LAST_I    = `CS_STEP_CYC - 1;
  localparam integer BLANK_LAST_I = BURST_BLANK - 1;

  localparam [5:0]  DEAD_LAST  = DEAD_LAST_I[5:0];
  localparam [16:0] SS_LAST    = SS_LAST_I[16:0];
  localparam [11:0] CS_LAST    = CS_LAST_I[11:0];
  localparam [15:0] BLANK_LAST = BLANK_LAST_I[15:0];

  reg [1:0]  mode_reg;
  reg [1:0]  mode_next;
  reg        phase_reg;
  reg        side_reg;
  reg [13:0] acc_reg;
  reg [5:0]  dead_cnt_reg;
  reg [16:0] ss_cnt_reg;
  reg [5:0]  ss_left_reg;
  reg [11:0] cs_cnt_reg;
  reg [6:0]  cs_part_reg;
  reg [15:0] blank_cnt_reg;

  wire       running = (mode_reg == MODE_SOFT) || (mode_reg == MODE_RUN);

  // Feedback part: inverse of feedback code, saturated at the window ends
  reg  [7:0]  fb_clamped;
  reg  [7:0]  fb_diff;
  reg  [16:0] fb_prod;
  reg  [6:0]  fb_part;
  always @* begin
    if (feedback_input < `FB_LO_CODE) begin
      fb_clamped = `FB_LO_CODE;
    end else if (feedback_input > `FB_HI_CODE) begin
      fb_clamped = `FB_HI_CODE;
    end else begin
      fb_clamped = feedback_input;
    end
    fb_diff = `FB_HI_CODE - fb_clamped;
    fb_prod = fb_diff * `FB_SCALE;
    if (fb_prod[16:10] > `FB_PART_MAX) begin
      fb_part = `FB_PART_MAX;
    end else begin
      fb_part = fb_prod[16:10];
    end
  end

  // Soft-start part scales with steps remaining
  wire [11:0] ss_prod = {6'h00, ss_left_reg} * {5'h00, `SS_PART_MAX};
  wire [6:0]  ss_part = (mode_reg == MODE_SOFT) ? ss_prod[11:5] : 7'h00;

  // Total rate and clamps
  reg  [8:0] rate_sum;
  reg  [6:0] rate_cap;
  reg  [6:0] rate;
  always @* begin
    rate_sum = {2'b00, `BASE_RATE} + {2'b00, fb_part}
             + {2'b00, cs_part_reg} + {2'b00, ss_part};
    if (mode_reg == MODE_SOFT) begin
      rate_cap = `CAP_SOFT;
    end else if (cs_part_reg != 7'h00) begin
      rate_cap = `CAP_FAULT;
    end else begin
      rate_cap = `CAP_NORMAL;
    end
    if (rate_cap > `CAP_ABS) begin
      rate_cap = `CAP_ABS;
    end
    if (rate_sum > {2'b00, rate_cap}) begin
      rate = rate_cap;
    end else begin
      rate = rate_sum[6:0];
    end
  end

  wire [13:0] acc_sum   = acc_reg + {7'h00, rate};
  wire        ramp_done = (acc_sum >= `RAMP_TOP);

  // Operating mode
  always @* begin
    mode_next = mode_reg;
    case (mode_reg)
      MODE_OFF: begin
        if (supply_on_level) begin
          mode_next = MODE_SOFT;
        end
      end
      MODE_SOFT: begin
        if (ss_left_reg == 6'h00) begin
          mode_next = MODE_RUN;
        end
      end
      MODE_RUN: begin
        if (burst_off_threshold && blank_cnt_reg == BLANK_LAST) begin
          mode_next = MODE_BURST;
        end
      end
      MODE_BURST: begin
        if (burst_on_threshold) begin
          mode_next = MODE_RUN;
        end
      end
      default: begin
        mode_next = MODE_OFF;
      end
    endcase
    if (mode_reg != MODE_OFF && supply_off_level) begin
      mode_next = MODE_OFF;
    end
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      mode_reg <= MODE_OFF;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Soft-start step timer
  always @(posedge clk_sys) begin
    if (srst || mode_reg == MODE_OFF) begin
      ss_cnt_reg  <= 17'h00000;
      ss_left_reg <= `SS_STEPS;
    end else if (mode_reg == MODE_SOFT) begin
      if (ss_cnt_reg == SS_LAST) begin
        ss_cnt_reg  <= 17'h00000;
        ss_left_reg <= ss_left_reg - 6'h01;
      end else begin
        ss_cnt_reg <= ss_cnt_reg + 17'h00001;
      end
    end
  end

  // Current-sense part ramp; between thresholds it holds for hysteresis
  always @(posedge clk_sys) begin
    if (srst || mode_reg == MODE_OFF) begin
      cs_cnt_reg  <= 12'h000;
      cs_part_reg <= 7'h00;
    end else if (cs_cnt_reg == CS_LAST) begin
      cs_cnt_reg <= 12'h000;
      if (cs_above_high && cs_part_reg < `CS_PART_MAX) begin
        cs_part_reg <= cs_part_reg + 7'h01;
      end else if (cs_below_low && cs_part_reg != 7'h00) begin
        cs_part_reg <= cs_part_reg - 7'h01;
      end
    end else begin
      cs_cnt_reg <= cs_cnt_reg + 12'h001;
    end
  end

  // Burst blanking timer restarts whenever feedback recovers
  always @(posedge clk_sys) begin
    if (srst || mode_reg != MODE_RUN || !burst_off_threshold) begin
      blank_cnt_reg <= 16'h0000;
    end else if (blank_cnt_reg != BLANK_LAST) begin
      blank_cnt_reg <= blank_cnt_reg + 16'h0001;
    end
  end

  // Oscillator: charge phase integrates rate, dead phase counts fixed time
  always @(posedge clk_sys) begin
    if (srst || !running) begin
      phase_reg    <= PH_CHARGE;
      side_reg     <= 1'b0;
      acc_reg      <= 14'h0000;
      dead_cnt_reg <= 6'h00;
    end else begin
      case (phase_reg)
        PH_CHARGE: begin
          if (ramp_done) begin
            phase_reg    <= PH_DEAD;
            acc_reg      <= 14'h0000;
            dead_cnt_reg <= 6'h00;
          end else begin
            acc_reg <= acc_sum;
          end
        end
        PH_DEAD: begin
          if (dead_cnt_reg == DEAD_LAST) begin
            phase_reg <= PH_CHARGE;
            side_reg  <= ~side_reg;
          end else begin
            dead_cnt_reg <= dead_cnt_reg + 6'h01;
          end
        end
        default: begin
          phase_reg <= PH_CHARGE;
        end
      endcase
    end
  end

  // Registered gates; the cycle a charge ends the active gate drops
  wire charge_on = running && (phase_reg == PH_CHARGE) && !ramp_done;
  always @(posedge clk_sys) begin
    if (srst) begin
      high_side_gate    <= 1'b0;
      low_side_gate     <= 1'b0;
      soft_start_active <= 1'b0;
      overload_enable   <= 1'b0;
      switching_active  <= 1'b0;
    end else begin
      high_side_gate    <= charge_on && !side_reg;
      low_side_gate     <= charge_on && side_reg;
      soft_start_active <= (mode_reg == MODE_SOFT);
      overload_enable   <= (mode_reg == MODE_RUN);
      switching_active  <= running;
    end
  end

endmodule

// [gate_ctl_checker_assertions.sv]
/* Port checker for half_bridge_gate_ctl, bound after the module.
   Assumes one clock and a synchronous active-high srst. */
`timescale 1ns/1ps
module gate_ctl_checker (
  input wire logic clk_sys, srst, supply_on_level, supply_off_level,
  input wire logic burst_off_threshold, high_side_gate, low_side_gate,
  input wire logic soft_start_active, overload_enable, switching_active
);
  logic [5:0] dead_reg;
  // Samples with both gates low, saturating
  always @(posedge clk_sys)
    if (srst || high_side_gate || low_side_gate) dead_reg <= 6'h00;
    else if (dead_reg != 6'h3F) dead_reg <= dead_reg + 6'h01;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_NO_OVERLAP: assert property (!(high_side_gate && low_side_gate))
    else $error("both gates high");
  AST_DEAD_TIME: assert property ($rose(low_side_gate) |-> dead_reg == 6'h26)
    else $error("dead time wrong");
  AST_HANDOVER:
    assert property ($fell(high_side_gate) |-> ##38 (low_side_gate || !switching_active))
    else $error("no low gate after dead time");
  AST_FIRST_HIGH: assert property ($rose(switching_active) |-> high_side_gate)
    else $error("first gate not high side");
  AST_IDLE: assert property (!switching_active |-> !(high_side_gate || low_side_gate))
    else $error("gate while stopped");
  AST_SS_NO_OLP: assert property (soft_start_active |-> !overload_enable)
    else $error("overload enabled in soft start");
  AST_DROP:
    assert property (supply_off_level && switching_active |-> ##2 !switching_active)
    else $error("no stop on supply drop");
  AST_START: assert property ($rose(soft_start_active) |-> $past(supply_on_level, 2))
    else $error("start without supply");
  AST_BURST:
    assert property ($fell(overload_enable) && !$past(supply_off_level, 2)
      |-> $past(burst_off_threshold, 2))
    else $error("stop without burst request");
endmodule
bind half_bridge_gate_ctl gate_ctl_checker i_chk (.clk_sys, .srst, .supply_on_level,
  .supply_off_level, .burst_off_threshold, .high_side_gate, .low_side_gate,
  .soft_start_active, .overload_enable, .switching_active);

// [bridge_switch_model.sv]
/* Model of the external half-bridge switch drivers.
   Assumes the switches follow the gate levels directly. */
`timescale 1ns/1ps
module bridge_switch_model (
  // Clock and gate drives
  input wire logic         clk_sys,
  input wire logic         high_side_gate,
  input wire logic         low_side_gate,
  // Cycles with both switches conducting
  output logic      [15:0] shoot_through
);
  initial shoot_through = 16'h0000;
  always @(posedge clk_sys)
    if (high_side_gate && low_side_gate) shoot_through <= shoot_through + 16'h0001;
endmodule

// [half_bridge_gate_ctl_tb.sv]
/* Self-checking bench for half_bridge_gate_ctl.
   Assumes shortened soft-start steps and burst blanking. */
`timescale 1ns/1ps
module half_bridge_gate_ctl_tb;
  logic        clk_sys = 1'b0, srst = 1'b1, supply_on_level = 1'b0, supply_off_level = 1'b0;
  logic        burst_off_threshold = 1'b0, burst_on_threshold = 1'b0;
  logic        cs_above_high = 1'b0, cs_below_low = 1'b1;
  logic  [7:0] feedback_input = 8'hC7;
  logic        high_side_gate, low_side_gate, soft_start_active, overload_enable;
  logic        switching_active;
  logic [15:0] shoot_through;
  int          n_errors = 0, comparisons = 0, w;
  always #5 clk_sys = ~clk_sys;
  half_bridge_gate_ctl #(.SS_STEP_CYCLES(50), .BURST_BLANK(20)) i_dut (.clk_sys, .srst,
    .supply_on_level, .supply_off_level, .feedback_input, .burst_off_threshold,
    .burst_on_threshold, .cs_above_high, .cs_below_low, .high_side_gate, .low_side_gate,
    .soft_start_active, .overload_enable, .switching_active);
  bridge_switch_model i_drv (.clk_sys, .high_side_gate, .low_side_gate, .shoot_through);
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input int lo, input int hi, input logic [15:0] got);
    comparisons++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      n_errors++;
      $display("wrong value %s expected %0d..%0d seen %0h", nm, lo, hi, got);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Index 4 high, 3 low, 2 soft, 1 overload, 0 switching
  task automatic wt(input int i, input logic v, input int lim);
    logic [4:0] s;
    repeat (lim) begin
      @(posedge clk_sys); #1;
      s = {high_side_gate, low_side_gate, soft_start_active, overload_enable, switching_active};
      if (s[i] === v) return;
    end
    chk("wait", 1, 0, i);
    end_of_test();
  endtask
  task automatic on_len(output int n);
    wt(4, 1'b0, 900); wt(4, 1'b1, 900);
    n = 1;
    while (high_side_gate === 1'b1 && n < 900) begin
      @(posedge clk_sys); #1; n++;
    end
  endtask
  task automatic t_start();
    tk(20); #1 chk("idle", 0, 0, {high_side_gate, low_side_gate, switching_active});
    @(posedge clk_sys) supply_on_level <= 1'b1;
    wt(2, 1'b1, 4);
    chk("first gate", 2, 2, {high_side_gate, low_side_gate});
    w = 0;
    while (soft_start_active === 1'b1 && w < 3000) begin
      @(posedge clk_sys); #1; w++;
    end
    chk("soft length", 1598, 1602, w);
    chk("run flags", 3, 3, {overload_enable, switching_active});
  endtask
  task automatic t_rate();
    on_len(w); chk("on fb top", 399, 401, w);
    @(posedge clk_sys) feedback_input <= 8'h2E;
    on_len(w); chk("on fb low", 136, 138, w);
    @(posedge clk_sys) feedback_input <= 8'h00;
    on_len(w); chk("on fb sat", 136, 138, w);
    @(posedge clk_sys) begin feedback_input <= 8'hC7; cs_above_high <= 1'b1; cs_below_low <= 1'b0; end
    tk(7000); on_len(w); chk("on cs up", 336, 357, w);
    @(posedge clk_sys) begin cs_above_high <= 1'b0; cs_below_low <= 1'b1; end
    tk(10000); on_len(w); chk("on cs down", 399, 401, w);
  endtask
  task automatic t_burst();
    @(posedge clk_sys) burst_off_threshold <= 1'b1;
    tk(15); #1 chk("blanking", 1, 1, switching_active);
    wt(0, 1'b0, 20);
    chk("burst gates", 0, 0, {high_side_gate, low_side_gate});
    tk(50); burst_off_threshold <= 1'b0; burst_on_threshold <= 1'b1;
    wt(0, 1'b1, 8);
    chk("resume gate", 2, 2, {high_side_gate, low_side_gate});
    @(posedge clk_sys) burst_on_threshold <= 1'b0;
  endtask
  task automatic t_drop();
    tk(100); supply_on_level <= 1'b0; supply_off_level <= 1'b1;
    tk(3); #1 chk("drop", 0, 0, {high_side_gate, low_side_gate, switching_active});
    @(posedge clk_sys) supply_off_level <= 1'b0;
    tk(30); #1 chk("stay off", 0, 0, switching_active);
    chk("overlap", 0, 0, shoot_through);
  endtask
  initial begin
    tk(6); srst <= 1'b0;
    t_start();
    t_rate();
    t_burst();
    t_drop();
    end_of_test();
  end
endmodule
